// file: hw/etu_retry_pkg.sv
// constants shared by the contact uart etu divider and parity retry block
// assumes an axi4-lite master on REF_CLK and a character engine beside it
package etu_retry_pkg;
  // register byte addresses
  localparam logic [5:0] OFF_DIV_LOW  = 6'h04;
  localparam logic [5:0] OFF_DIV_HIGH = 6'h0c;
  localparam logic [5:0] OFF_FEC      = 6'h20;
  localparam logic [5:0] OFF_STATUS   = 6'h24;
  localparam logic [5:0] OFF_MASK     = 6'h28;
  localparam logic [5:0] OFF_SLOT     = 6'h2c;
  // reset values
  localparam logic [7:0]  DIV_LOW_RESET  = 8'h74;
  localparam logic [7:0]  DIV_HIGH_RESET = 8'h01;
  localparam logic [15:0] DIV_RESET      = {DIV_HIGH_RESET, DIV_LOW_RESET};
  localparam logic [9:0]  FEC_RESET      = 10'h000;
  // fifo_error_control fields
  localparam int LIMIT_LSB = 5;
  localparam int LIMIT_W   = 3;
  localparam int T1_BIT    = 8;
  localparam int DISPE_BIT = 9;
  // status / mask fields
  localparam int FT_BIT    = 0;
  localparam int PE_BIT    = 1;
  localparam int HALT_BIT  = 2;
  localparam int CNT_LSB   = 4;
  localparam int STAT_W    = 2;
  // slot_select_register field
  localparam int AUX_BIT   = 1;
  // character pacing in etus from character start
  localparam logic [3:0] RESEND_ETU = 4'hf;
  localparam logic [3:0] NEXT_ETU   = 4'hd;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    PACE_IDLE   = 3'b001,
    PACE_NEXT   = 3'b010,
    PACE_RESEND = 3'b100
  } pace_type;
endpackage

// file: hw/line_sync.sv
// two-flop synchroniser with rising edge detect
// assumes din is asynchronous to clk and slower than clk / 2
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // pin and edge
  input  wire logic din,
  output logic      rise
);
  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds stage2 only, the edge detect looks at stage2 onward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      rise   <= 1'b0;
    end else if (ce) begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      rise   <= stage2 & ~stage3;
    end
  end
endmodule
`default_nettype wire

// file: hw/etu_timer.sv
// etu counter: counts interface clock edges up to the 16-bit divider
// assumes divider is at least 16, so ticks never run back to back
`timescale 1ns/1ps
`default_nettype none
module etu_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // count source and setting
  input  wire logic        step,
  input  wire logic [15:0] divider,
  // etu boundary
  output logic             tick
);
  logic [15:0] count;
  logic [15:0] active_div;
  wire         last = step && (count == active_div - 16'h0001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count      <= 16'h0000;
      active_div <= etu_retry_pkg::DIV_RESET;
      tick       <= 1'b0;
    end else if (ce) begin
      tick <= last;
      if (last) begin
        count      <= 16'h0000;
        // new setting waits for the boundary, so no unit is cut short
        active_div <= divider;
      end else if (step) begin
        count <= count + 16'h0001;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_tick_reload;
    ce && last |=> tick && count == 16'h0000;
  endproperty
  a_tick_reload: assert property (p_tick_reload)
    else $error("etu tick or reload missing at divider count");

  property p_div_boundary;
    !(ce && last) |=> $stable(active_div);
  endproperty
  a_div_boundary: assert property (p_div_boundary)
    else $error("divider changed inside an etu");
endmodule
`default_nettype wire

// file: hw/contact_uart_etu_retry.sv
// contact uart etu divider and t=0 parity retry control, axi4-lite slave
// assumes a character engine on REF_CLK reporting characters and acks
// Functional notes
// - etu counts interface clock cycles to divider
// - divider is low and high byte, reset 0x174
// - each divider byte banked per slot, one address
// - retry limit 000 flags one error, 111 eight
// - good received character clears error counter
// - nacked character resent automatically at 15 etu
// - accepted character clears counter before limit
// - nonzero limit plus one nacks halts, sets parity flag
// - threshold and parity flags are interrupt sources
// - limit zero: no resend, next at 13
// - t=1 flags parity on first bad character
// - aux select routes to auxiliary slot settings
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module contact_uart_etu_retry (
  // clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // axi4-lite write
  input  wire logic [5:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read
  input  wire logic [5:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // contact interface clock pin
  input  wire logic        CI_CLK,
  // character engine events
  input  wire logic        RX_CHAR_DONE,
  input  wire logic        RX_PARITY_BAD,
  input  wire logic        TX_CHAR_START,
  input  wire logic        TX_CHAR_ACK,
  input  wire logic        TX_CHAR_NACK,
  input  wire logic        FIFO_THRESHOLD,
  // to character engine
  output logic             ETU_TICK,
  output logic             TX_NEXT,
  output logic             TX_RESEND,
  output logic             TX_HALT,
  output logic             PARITY_CHECK_DISABLE,
  output logic             AUX_SLOT,
  // interrupt
  output logic             IRQ
);
  // bus state
  logic        aw_held;
  logic [5:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] rd_value;
  logic        rd_ok;
  // registers
  logic [7:0]  div_low [2];
  logic [7:0]  div_high [2];
  logic [9:0]  fec;
  localparam int STAT_W_L = etu_retry_pkg::STAT_W;
  logic [STAT_W_L-1:0] status;
  logic [STAT_W_L-1:0] mask;
  logic        aux;
  // retry state
  logic [3:0]  err_cnt;
  logic [3:0]  gap;
  etu_retry_pkg::pace_type pace;
  logic        ci_rise;

  // write decode
  wire do_write = aw_held && w_held && !BVALID;
  wire a_low    = aw_addr == etu_retry_pkg::OFF_DIV_LOW;
  wire a_high   = aw_addr == etu_retry_pkg::OFF_DIV_HIGH;
  wire a_fec    = aw_addr == etu_retry_pkg::OFF_FEC;
  wire a_stat   = aw_addr == etu_retry_pkg::OFF_STATUS;
  wire a_mask   = aw_addr == etu_retry_pkg::OFF_MASK;
  wire a_slot   = aw_addr == etu_retry_pkg::OFF_SLOT;
  wire wr_ok    = a_low | a_high | a_fec | a_stat | a_mask | a_slot;
  wire wr_low   = do_write && a_low && w_strb[0];
  wire wr_high  = do_write && a_high && w_strb[0];
  wire wr_fec0  = do_write && a_fec && w_strb[0];
  wire wr_fec1  = do_write && a_fec && w_strb[1];
  wire wr_stat  = do_write && a_stat && w_strb[0];
  wire wr_mask  = do_write && a_mask && w_strb[0];
  wire wr_slot  = do_write && a_slot && w_strb[0];
  wire new_aux  = w_data[etu_retry_pkg::AUX_BIT];
  wire slot_chg = wr_slot && (new_aux != aux);

  assign AWREADY = !aw_held && !BVALID;
  assign WREADY  = !w_held && !BVALID;
  assign ARREADY = !RVALID;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 6'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= etu_retry_pkg::RESP_OKAY;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_ok ? etu_retry_pkg::RESP_OKAY
                         : etu_retry_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok    = 1'b1;
    if (ARADDR == etu_retry_pkg::OFF_DIV_LOW) begin
      rd_value[7:0] = div_low[aux];
    end else if (ARADDR == etu_retry_pkg::OFF_DIV_HIGH) begin
      rd_value[7:0] = div_high[aux];
    end else if (ARADDR == etu_retry_pkg::OFF_FEC) begin
      rd_value[9:0] = fec;
    end else if (ARADDR == etu_retry_pkg::OFF_STATUS) begin
      rd_value[STAT_W_L-1:0]                  = status;
      rd_value[etu_retry_pkg::HALT_BIT]       = TX_HALT;
      rd_value[etu_retry_pkg::CNT_LSB +: 4]   = err_cnt;
    end else if (ARADDR == etu_retry_pkg::OFF_MASK) begin
      rd_value[STAT_W_L-1:0] = mask;
    end else if (ARADDR == etu_retry_pkg::OFF_SLOT) begin
      rd_value[etu_retry_pkg::AUX_BIT] = aux;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= etu_retry_pkg::RESP_OKAY;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA  <= rd_value;
        RRESP  <= rd_ok ? etu_retry_pkg::RESP_OKAY
                        : etu_retry_pkg::RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // banked divider bytes, one copy per slot
  for (genvar g = 0; g < 2; g++) begin : bank
    wire sel = aux == 1'(g);
    always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
        div_low[g]  <= etu_retry_pkg::DIV_LOW_RESET;
        div_high[g] <= etu_retry_pkg::DIV_HIGH_RESET;
      end else if (CE) begin
        if (wr_low && sel)
          div_low[g] <= w_data[7:0];
        if (wr_high && sel)
          div_high[g] <= w_data[7:0];
      end
    end
  end

  // fields of fifo_error_control
  wire [2:0] limit = fec[etu_retry_pkg::LIMIT_LSB +: etu_retry_pkg::LIMIT_W];
  wire       t1    = fec[etu_retry_pkg::T1_BIT];
  wire       dispe = fec[etu_retry_pkg::DISPE_BIT];
  wire [3:0] limit_plus = {1'b0, limit} + 4'h1;
  wire [3:0] cnt_inc    = err_cnt + 4'h1;
  wire       cnt_full   = cnt_inc == limit_plus;
  wire       rx_bad     = RX_CHAR_DONE && RX_PARITY_BAD && !dispe;
  wire       rx_good    = RX_CHAR_DONE && !RX_PARITY_BAD;
  wire       tx_nack    = TX_CHAR_NACK && !t1 && !dispe && !TX_HALT;
  wire       nack_halt  = tx_nack && limit != 3'h0 && cnt_full;
  wire       nack_retry = tx_nack && limit != 3'h0 && !cnt_full;
  wire       nack_zero  = tx_nack && limit == 3'h0;
  wire       rx_pe      = rx_bad && (t1 || cnt_full);
  wire       set_pe     = rx_pe || nack_halt || nack_zero;
  wire [STAT_W_L-1:0] set_bits = {set_pe, FIFO_THRESHOLD};
  wire [STAT_W_L-1:0] clr_bits = wr_stat ? w_data[STAT_W_L-1:0]
                                         : {STAT_W_L{1'b0}};
  wire [STAT_W_L-1:0] keep     = slot_chg ? {STAT_W_L{1'b0}} : ~clr_bits;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fec    <= etu_retry_pkg::FEC_RESET;
      mask   <= {STAT_W_L{1'b0}};
      aux    <= 1'b0;
      status <= {STAT_W_L{1'b0}};
      IRQ    <= 1'b0;
    end else if (CE) begin
      if (wr_fec0)
        fec[7:0] <= w_data[7:0];
      if (wr_fec1)
        fec[9:8] <= w_data[9:8];
      if (wr_mask)
        mask <= w_data[STAT_W_L-1:0];
      if (wr_slot)
        aux <= new_aux;
      // a new event wins over a clear in the same cycle
      status <= (status & keep) | set_bits;
      IRQ    <= |(status & mask);
    end
  end

  // error counter, halt and pacing
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      err_cnt   <= 4'h0;
      TX_HALT   <= 1'b0;
      gap       <= 4'h0;
      pace      <= etu_retry_pkg::PACE_IDLE;
      TX_NEXT   <= 1'b0;
      TX_RESEND <= 1'b0;
    end else if (CE) begin
      TX_NEXT   <= 1'b0;
      TX_RESEND <= 1'b0;
      if (slot_chg) begin
        err_cnt <= 4'h0;
      end else if (nack_halt || nack_zero) begin
        err_cnt <= 4'h0;
      end else if (nack_retry) begin
        err_cnt <= cnt_inc;
      end else if (TX_CHAR_ACK && !t1) begin
        err_cnt <= 4'h0;
      end else if (rx_bad && !t1) begin
        err_cnt <= cnt_full ? 4'h0 : cnt_inc;
      end else if (rx_good && !t1) begin
        err_cnt <= 4'h0;
      end
      // a disable pulse from firmware unlocks a halted transmitter
      if (nack_halt)
        TX_HALT <= 1'b1;
      else if (dispe || slot_chg)
        TX_HALT <= 1'b0;
      if (TX_CHAR_START)
        gap <= 4'h0;
      else if (ETU_TICK && gap != etu_retry_pkg::RESEND_ETU)
        gap <= gap + 4'h1;
      case (pace)
        etu_retry_pkg::PACE_IDLE: begin
          if (nack_retry)
            pace <= etu_retry_pkg::PACE_RESEND;
          else if (TX_CHAR_ACK || nack_zero || (TX_CHAR_NACK && t1))
            pace <= etu_retry_pkg::PACE_NEXT;
        end
        etu_retry_pkg::PACE_NEXT: begin
          if (nack_halt || TX_CHAR_START) begin
            pace <= etu_retry_pkg::PACE_IDLE;
          end else if (gap >= etu_retry_pkg::NEXT_ETU) begin
            TX_NEXT <= !TX_HALT;
            pace    <= etu_retry_pkg::PACE_IDLE;
          end
        end
        etu_retry_pkg::PACE_RESEND: begin
          if (TX_CHAR_START) begin
            pace <= etu_retry_pkg::PACE_IDLE;
          end else if (gap >= etu_retry_pkg::RESEND_ETU) begin
            TX_RESEND <= 1'b1;
            pace      <= etu_retry_pkg::PACE_IDLE;
          end
        end
        default: pace <= etu_retry_pkg::PACE_IDLE;
      endcase
    end
  end

  assign PARITY_CHECK_DISABLE = dispe;
  assign AUX_SLOT             = aux;

  // interface clock edges drive the etu; divider itself must stay >= 16
  line_sync ci_sync (
    .clk  (REF_CLK),
    .rst  (RST),
    .ce   (CE),
    .din  (CI_CLK),
    .rise (ci_rise)
  );

  etu_timer etu (
    .clk     (REF_CLK),
    .rst     (RST),
    .ce      (CE),
    .step    (ci_rise),
    .divider ({div_high[aux], div_low[aux]}),
    .tick    (ETU_TICK)
  );

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_halt;
    CE && tx_nack && limit != 3'h0 && err_cnt == {1'b0, limit} |=>
      TX_HALT && status[etu_retry_pkg::PE_BIT];
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt or parity flag missing after last nack");

  property p_rx_limit;
    CE && !t1 && rx_bad && err_cnt == {1'b0, limit} |=>
      status[etu_retry_pkg::PE_BIT] && err_cnt == 4'h0;
  endproperty
  a_rx_limit: assert property (p_rx_limit)
    else $error("parity flag missing at programmed error count");

  property p_rx_good;
    CE && !t1 && rx_good && !tx_nack && !TX_CHAR_ACK && !slot_chg |=>
      err_cnt == 4'h0;
  endproperty
  a_rx_good: assert property (p_rx_good)
    else $error("good character did not clear error count");

  property p_ack_clear;
    CE && !t1 && TX_CHAR_ACK && !tx_nack |=> err_cnt == 4'h0;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("accepted character did not clear error count");

  property p_resend_gap;
    CE && TX_RESEND |-> $past(gap) == etu_retry_pkg::RESEND_ETU;
  endproperty
  a_resend_gap: assert property (p_resend_gap)
    else $error("resend not at 15 etu");

  property p_zero_limit;
    CE && nack_zero && !TX_HALT |=>
      !TX_HALT && pace != etu_retry_pkg::PACE_RESEND;
  endproperty
  a_zero_limit: assert property (p_zero_limit)
    else $error("retry limit zero caused a resend or halt");

  property p_t1_first;
    CE && t1 && rx_bad |=> status[etu_retry_pkg::PE_BIT] && $stable(err_cnt);
  endproperty
  a_t1_first: assert property (p_t1_first)
    else $error("t=1 bad character did not flag parity");

  property p_threshold;
    CE && FIFO_THRESHOLD |=> status[etu_retry_pkg::FT_BIT] ##1
      (IRQ == mask[etu_retry_pkg::FT_BIT] || $past(mask) != mask || IRQ);
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("threshold flag or interrupt missing");

  property p_bank;
    CE && wr_low && !aux |=> $stable(div_low[1]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("full slot write reached auxiliary divider");

  cover property (CE && TX_RESEND);
  cover property (CE && nack_halt);
  cover property (CE && TX_NEXT);
endmodule
`default_nettype wire

// file: testbench/card_model.sv
// card and character engine stand-in: card clock and transmit answers
// assumes pacing pulses from the etu retry block, sampled on clk
`timescale 1ns/1ps
`default_nettype none
module card_model (
  // clock
  input  wire logic clk,
  // pacing from the block
  input  wire logic etu_tick,
  input  wire logic tx_resend,
  input  wire logic tx_next,
  input  wire logic tx_halt,
  // card side
  output logic      ci_clk,
  output logic      tx_start,
  output logic      tx_ack,
  output logic      tx_nack
);
  // card clock runs free while active; odd phase against clk
  initial begin
    tx_start = 1'b0;
    tx_ack = 1'b0;
    tx_nack = 1'b0;
    ci_clk = 1'b0;
    #7;
    forever #160 ci_clk = ~ci_clk;
  end

  // answer 11 etu into each attempt, after the error window
  task automatic send_char(input int nacks);
    int left;
    int n;
    logic more;
    left = nacks;
    more = 1'b1;
    while (more) begin
      @(posedge clk) tx_start <= 1'b1;
      @(posedge clk) tx_start <= 1'b0;
      n = 0;
      while (n < 11) begin
        @(posedge clk);
        if (etu_tick === 1'b1) n++;
      end
      if (left > 0) tx_nack <= 1'b1;
      else tx_ack <= 1'b1;
      left--;
      @(posedge clk);
      tx_nack <= 1'b0;
      tx_ack <= 1'b0;
      n = 0;
      while (n < 40000 && tx_resend !== 1'b1 && tx_next !== 1'b1
             && tx_halt !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      more = (tx_resend === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/test_contact_uart_etu_and_parity_retry.sv
// self-checking bench for the etu divider and parity retry block
// assumes card_model supplies the card clock and transmit answers
`timescale 1ns/1ps
`default_nettype none
module test_contact_uart_etu_and_parity_retry;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd, rdata;
  logic [1:0]  resp, bresp, rresp;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        rx_done = 0, rx_bad = 0, thr = 0;
  logic        awready, wready, bvalid, arready, rvalid, tick, nxt, res;
  logic        halt, unlock, aux, irq, ci_clk, start, ack, nack;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, n_res = 0;
  int          gap = 0, gap_res = 0, gap_next = 0, ex_res, ex_halt, ex_pe;
  int          lim[3] = '{0, 7, 0}, tl[4] = '{2, 1, 0, 0}, tn[4] = '{2, 2, 1, 0};

  always #20 clk = ~clk;

  contact_uart_etu_retry uut (
    .REF_CLK(clk), .RST(rst), .CE(1'b1),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CI_CLK(ci_clk), .RX_CHAR_DONE(rx_done), .RX_PARITY_BAD(rx_bad),
    .TX_CHAR_START(start), .TX_CHAR_ACK(ack), .TX_CHAR_NACK(nack),
    .FIFO_THRESHOLD(thr), .ETU_TICK(tick), .TX_NEXT(nxt),
    .TX_RESEND(res), .TX_HALT(halt), .PARITY_CHECK_DISABLE(unlock),
    .AUX_SLOT(aux), .IRQ(irq));

  card_model partner (
    .clk(clk), .etu_tick(tick), .tx_resend(res), .tx_next(nxt),
    .tx_halt(halt), .ci_clk(ci_clk), .tx_start(start), .tx_ack(ack),
    .tx_nack(nack));

  // etu gap since character start, as seen at each pacing pulse
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) gap = 0;
    else if (tick === 1'b1) gap++;
    if (res === 1'b1) begin
      n_res++;
      gap_res = gap;
    end
    if (nxt === 1'b1) gap_next = gap;
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    logic ad, wd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [5:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    axr(a);
    chk(rd & m, e);
  endtask

  task automatic rx(input logic bad);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_bad <= bad;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_bad <= 1'b0;
  endtask

  // irq trails status by a cycle, so let two edges pass first
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk(irq, e);
  endtask

  // card clock is 8 reference cycles, so one etu is divider * 8
  task automatic etu_period(input int div);
    int n;
    n = 0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
    chkn(n, div * 8);
  endtask

  initial begin
    void'($urandom(53));
    lim[2] = $urandom % 8;
    tl[3] = 1 + $urandom % 3;
    tn[3] = $urandom % (tl[3] + 2);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(etu_retry_pkg::OFF_DIV_LOW, 32'hff, 32'h74);
    rdchk(etu_retry_pkg::OFF_DIV_HIGH, 32'hff, 32'h01);
    etu_period(32'h174);
    axr(6'h3c);
    chk(resp, etu_retry_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    axw(6'h3c, 32'h2);
    chk(resp, etu_retry_pkg::RESP_SLVERR);
    chk(aux, 1'b0);
    axw(etu_retry_pkg::OFF_SLOT, 32'h2);
    chk(resp, etu_retry_pkg::RESP_OKAY);
    chk(aux, 1'b1);
    rdchk(etu_retry_pkg::OFF_DIV_LOW, 32'hff, 32'h74);
    axw(etu_retry_pkg::OFF_DIV_LOW, 32'h10);
    axw(etu_retry_pkg::OFF_DIV_HIGH, 32'h0);
    etu_period(16);
    axw(etu_retry_pkg::OFF_SLOT, 32'h0);
    rdchk(etu_retry_pkg::OFF_DIV_LOW, 32'hff, 32'h74);
    axw(etu_retry_pkg::OFF_DIV_LOW, 32'h10);
    axw(etu_retry_pkg::OFF_DIV_HIGH, 32'h0);
    etu_period(16);
    for (int i = 0; i < 3; i++) begin
      axw(etu_retry_pkg::OFF_FEC, lim[i] << 5);
      repeat (lim[i]) rx(1'b1);
      rx(1'b0);
      repeat (lim[i]) rx(1'b1);
      rdchk(etu_retry_pkg::OFF_STATUS, 32'h7, 32'h0);
      rx(1'b1);
      rdchk(etu_retry_pkg::OFF_STATUS, 32'h7, 32'h2);
      axw(etu_retry_pkg::OFF_STATUS, 32'h3);
    end
    axw(etu_retry_pkg::OFF_FEC, 32'h1e0);
    rx(1'b1);
    rdchk(etu_retry_pkg::OFF_STATUS, 32'h7, 32'h2);
    axw(etu_retry_pkg::OFF_STATUS, 32'h3);
    axw(etu_retry_pkg::OFF_MASK, 32'h0);
    @(posedge clk) thr <= 1'b1;
    @(posedge clk) thr <= 1'b0;
    rdchk(etu_retry_pkg::OFF_STATUS, 32'h7, 32'h1);
    irq_chk(1'b0);
    axw(etu_retry_pkg::OFF_MASK, 32'h3);
    irq_chk(1'b1);
    axw(etu_retry_pkg::OFF_STATUS, 32'h1);
    irq_chk(1'b0);
    for (int i = 0; i < 4; i++) begin
      axw(etu_retry_pkg::OFF_FEC, tl[i] << 5);
      n_res = 0;
      gap_res = 0;
      gap_next = 0;
      partner.send_char(tn[i]);
      repeat (2) @(posedge clk);
      ex_pe = tn[i] > tl[i];
      ex_halt = ex_pe && tl[i] > 0;
      ex_res = (tn[i] < tl[i]) ? tn[i] : tl[i];
      chkn(n_res, ex_res);
      if (ex_res > 0) chkn(gap_res, 15);
      if (ex_halt == 0) chkn(gap_next, 13);
      rdchk(etu_retry_pkg::OFF_STATUS, ex_pe ? 32'h7 : 32'hf7,
            (ex_halt << 2) | (ex_pe << 1));
      chk(halt, ex_halt);
      irq_chk(ex_pe);
      axw(etu_retry_pkg::OFF_FEC, 32'h200 | (tl[i] << 5));
      chk(unlock, 1'b1);
      axw(etu_retry_pkg::OFF_FEC, tl[i] << 5);
      chk(halt, 1'b0);
      axw(etu_retry_pkg::OFF_STATUS, 32'h3);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
